/* ddpd_pkg.sv */
// ddpd_pkg: shared constants and types for the transfer engine.
// assumes a 10 MHz core clock and a 2 MHz pacer reference pin.
package ddpd_pkg;

  // -----------------------------------------------------------------
  // register byte offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_DIV_IN = 8'h0C;
  localparam logic [7:0] OFS_DIV_OUT = 8'h10;
  localparam logic [7:0] OFS_DIV_PRE = 8'h14;
  localparam logic [7:0] OFS_DI_BASE = 8'h18;
  localparam logic [7:0] OFS_DI_BYTES = 8'h1C;
  localparam logic [7:0] OFS_DO_BASE = 8'h20;
  localparam logic [7:0] OFS_DO_SAMPLES = 8'h24;
  localparam logic [7:0] OFS_DI_DONE = 8'h28;
  localparam logic [7:0] OFS_DO_DONE = 8'h2C;
  localparam logic [7:0] OFS_OVERRUN = 8'h30;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h38;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int CFG_DI_CASC = 0;
  localparam int CFG_DO_CASC = 1;
  localparam int CFG_DO_REPEAT = 2;
  localparam int CFG_DBL_BUF = 3;
  localparam int CFG_DI_MODE = 4;
  localparam int CFG_DO_MODE = 6;
  localparam int CMD_DI_START = 0;
  localparam int CMD_DI_STOP = 1;
  localparam int CMD_DO_START = 2;
  localparam int CMD_DO_STOP = 3;
  localparam int CMD_HALF_TAKE = 4;
  localparam int ST_DI_RUN = 0;
  localparam int ST_DO_RUN = 1;
  localparam int ST_HALF_READY = 2;
  localparam int ST_READY_HALF = 3;
  localparam int ST_HALF_ERR = 4;
  localparam int IRQ_DI_DONE = 0;
  localparam int IRQ_DO_DONE = 1;
  localparam int IRQ_HALF = 2;
  localparam int IRQ_OVERRUN = 3;
  localparam int DIV_IN = 0;
  localparam int DIV_OUT = 1;
  localparam int DIV_PRE = 2;

  // -----------------------------------------------------------------
  // reset values and limits
  // -----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0002;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [26:0] MAX_BYTES = 27'h4000000;
  localparam logic [24:0] MAX_WORDS = 25'h1000000;

  // -----------------------------------------------------------------
  // modes and states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    DI_PACER = 2'b00,
    DI_RISE = 2'b01,
    DI_FALL = 2'b10,
    DI_HSHAKE = 2'b11
  } ddpd_di_mode_type;

  typedef enum logic [1:0] {
    DO_PACER = 2'b00,
    DO_GATED = 2'b01,
    DO_HSHAKE = 2'b10
  } ddpd_do_mode_type;

  typedef enum logic [1:0] {
    BM_IDLE = 2'b00,
    BM_WRITE = 2'b01,
    BM_READ = 2'b10
  } ddpd_bm_type;

endpackage

/* ddpd_divider.sv */
// ddpd_divider: one 16-bit reloading pacer divider.
// assumes step is a one-cycle pulse and divisor is 2 or more.
`timescale 1ns/10ps
module ddpd_divider (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic step,
  input wire logic [15:0] divisor,
  // tick out
  output logic tick
);

  logic [15:0] cnt, next_cnt;
  logic next_tick;

  // reload on terminal count keeps the tick period constant
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = divisor;
    end else if (step) begin
      if (cnt <= 16'h0001) begin
        next_cnt = divisor;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= ddpd_pkg::DIV_RESET;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  property p_reload;
    @(posedge core_clk) disable iff (!reset_n)
    run && step && cnt <= 16'h0001 |=> tick && cnt == $past(divisor);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");

endmodule

/* ddpd_top.sv */
// ddpd_top: bus-master transfer engine with pacers and ring input.
// assumes a memory port that answers each request with one ack pulse.
// Notes on behaviour
// - single input pacer: reference over divider zero
// - chained: prescaler feeds input divider
// - output pacer: divider one, optionally chained
// - output modes: pacer, gated pacer, handshake
// - repeat restarts from buffer start until stopped
// - output status running flag and word count
// - done count stays readable after the end
// - ring input: two halves, wraps to first
// - half ready on crossing; early take flags error
// - unconsumed half overwritten counts an overrun
// - transfers limited to 64 MB
// - only handshake input never loses samples
// - output count in samples, exactly that many
// - input modes: pacer, rise, fall, handshake
// - byte count up to 2^26, word moves
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
module ddpd_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // interrupt
  output logic irq,
  // pacer reference pin
  input wire logic ref_clk_pin,
  // input port pins
  input wire logic [31:0] in_data,
  input wire logic in_req,
  output logic in_ack,
  // output port pins
  output logic [31:0] out_data,
  output logic out_strobe,
  input wire logic out_req,
  output logic out_ack,
  // bus master port
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [2:0] pins, filt, filt_d, rise, fall;
  logic [2:0] sh [3];
  assign pins = {out_req, in_req, ref_clk_pin};
  assign rise = filt & ~filt_d;
  assign fall = ~filt & filt_d;

  // a level is taken only once the second and third flops agree
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) begin
        sh[i] <= 3'h0;
      end
      filt <= 3'h0;
      filt_d <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        sh[i] <= {sh[i][1:0], pins[i]};
        if (sh[i][1] == sh[i][2]) begin
          filt[i] <= sh[i][2];
        end
      end
      filt_d <= filt;
    end
  end

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [7:0] cfg, next_cfg;
  logic [15:0] div [3];
  logic [15:0] next_div [3];
  logic [31:0] di_base, next_di_base, do_base, next_do_base;
  logic [26:0] di_bytes, next_di_bytes;
  logic [24:0] do_count, next_do_count;
  logic [3:0] irq_mask, next_irq_mask, irq_stat, next_irq_stat;
  logic di_run, next_di_run, do_run, next_do_run;
  logic di_full, next_di_full, do_full, next_do_full;
  logic [31:0] do_hold, next_do_hold;
  logic [24:0] di_idx, next_di_idx, di_done, next_di_done;
  logic [24:0] do_idx, next_do_idx, do_done, next_do_done;
  logic half_ready, next_half_ready, ready_half, next_ready_half;
  logic half_err, next_half_err;
  logic [31:0] overrun, next_overrun;
  ddpd_pkg::ddpd_bm_type bm, next_bm;
  logic next_mem_req, next_mem_we, next_in_ack, next_out_ack;
  logic [31:0] next_mem_addr, next_mem_wdata, next_out_data;
  logic next_out_strobe, next_irq;
  logic [31:0] next_reg_rdata;
  logic [24:0] di_words, di_half;
  logic di_ok, do_ok, cmd_wr, in_event, out_event;
  ddpd_pkg::ddpd_di_mode_type di_mode;
  ddpd_pkg::ddpd_do_mode_type do_mode;

  assign di_mode = ddpd_pkg::ddpd_di_mode_type'(cfg[5:4]);
  assign do_mode = ddpd_pkg::ddpd_do_mode_type'(cfg[7:6]);
  assign di_words = di_bytes[26:2];
  assign di_half = {1'b0, di_words[24:1]};
  assign cmd_wr = reg_wr && reg_addr == ddpd_pkg::OFS_CMD;
  // misaligned or oversized starts are refused, run stays low
  assign di_ok = di_base[1:0] == 2'b00 && di_bytes[1:0] == 2'b00 &&
                 di_bytes != 27'h0 && di_bytes <= ddpd_pkg::MAX_BYTES;
  assign do_ok = do_base[1:0] == 2'b00 && do_count != 25'h0 &&
                 do_count <= ddpd_pkg::MAX_WORDS;

  // -----------------------------------------------------------------
  // pacers
  // -----------------------------------------------------------------
  logic [2:0] div_run, div_step, div_tick;
  assign div_run = {di_run | do_run, do_run, di_run};
  assign div_step[ddpd_pkg::DIV_PRE] = rise[0];
  assign div_step[ddpd_pkg::DIV_IN] = cfg[ddpd_pkg::CFG_DI_CASC] ?
    div_tick[ddpd_pkg::DIV_PRE] : rise[0];
  assign div_step[ddpd_pkg::DIV_OUT] = cfg[ddpd_pkg::CFG_DO_CASC] ?
    div_tick[ddpd_pkg::DIV_PRE] : rise[0];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_div
      ddpd_divider u_div (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .run(div_run[gi]),
        .step(div_step[gi]),
        .divisor(div[gi]),
        .tick(div_tick[gi])
      );
    end
  endgenerate

  // sample events; free-running modes drop samples when the holder
  // is still full, only handshake waits for room
  always_comb begin
    case (di_mode)
      ddpd_pkg::DI_PACER: in_event = div_tick[ddpd_pkg::DIV_IN];
      ddpd_pkg::DI_RISE: in_event = rise[1];
      ddpd_pkg::DI_FALL: in_event = fall[1];
      ddpd_pkg::DI_HSHAKE: in_event = filt[1] && !in_ack;
      default: in_event = 1'b0;
    endcase
    case (do_mode)
      ddpd_pkg::DO_PACER: out_event = div_tick[ddpd_pkg::DIV_OUT];
      ddpd_pkg::DO_GATED: out_event = div_tick[ddpd_pkg::DIV_OUT] &&
                                      filt[2];
      ddpd_pkg::DO_HSHAKE: out_event = filt[2] && !out_ack;
      default: out_event = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // engine and register file
  // -----------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    next_div = div;
    next_di_base = di_base;
    next_do_base = do_base;
    next_di_bytes = di_bytes;
    next_do_count = do_count;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_di_run = di_run;
    next_do_run = do_run;
    next_di_full = di_full;
    next_do_full = do_full;
    next_do_hold = do_hold;
    next_di_idx = di_idx;
    next_di_done = di_done;
    next_do_idx = do_idx;
    next_do_done = do_done;
    next_half_ready = half_ready;
    next_ready_half = ready_half;
    next_half_err = half_err;
    next_overrun = overrun;
    next_bm = bm;
    next_mem_req = mem_req;
    next_mem_we = mem_we;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_out_data = out_data;
    next_out_strobe = 1'b0;
    next_in_ack = in_ack && filt[1];
    next_out_ack = out_ack && filt[2];
    next_reg_rdata = 32'h0;
    // software writes; clears come first so that events below win
    if (reg_wr) begin
      case (reg_addr)
        ddpd_pkg::OFS_CFG: next_cfg = reg_wdata[7:0];
        ddpd_pkg::OFS_DIV_IN: next_div[0] = reg_wdata[15:0];
        ddpd_pkg::OFS_DIV_OUT: next_div[1] = reg_wdata[15:0];
        ddpd_pkg::OFS_DIV_PRE: next_div[2] = reg_wdata[15:0];
        ddpd_pkg::OFS_DI_BASE: next_di_base = reg_wdata;
        ddpd_pkg::OFS_DI_BYTES: next_di_bytes = reg_wdata[26:0];
        ddpd_pkg::OFS_DO_BASE: next_do_base = reg_wdata;
        ddpd_pkg::OFS_DO_SAMPLES: next_do_count = reg_wdata[24:0];
        ddpd_pkg::OFS_IRQ_STAT: next_irq_stat = irq_stat & ~reg_wdata[3:0];
        ddpd_pkg::OFS_IRQ_MASK: next_irq_mask = reg_wdata[3:0];
        ddpd_pkg::OFS_CMD: begin
          if (reg_wdata[ddpd_pkg::CMD_HALF_TAKE]) begin
            next_half_ready = 1'b0;
            next_half_err = !half_ready;
          end
        end
        default: ;
      endcase
    end
    // input capture into the single holder
    if (in_event && di_run && !di_full) begin
      next_di_full = 1'b1;
      next_mem_wdata = in_data;
      next_in_ack = di_mode == ddpd_pkg::DI_HSHAKE;
    end
    // output emit, one sample per event
    if (out_event && do_run && do_full) begin
      next_out_data = do_hold;
      next_out_strobe = 1'b1;
      next_do_full = 1'b0;
      next_do_done = do_done + 25'h1;
      next_out_ack = do_mode == ddpd_pkg::DO_HSHAKE;
      if (!cfg[ddpd_pkg::CFG_DO_REPEAT] && next_do_done == do_count) begin
        next_do_run = 1'b0;
        next_irq_stat[ddpd_pkg::IRQ_DO_DONE] = 1'b1;
      end
    end
    // bus master, writes ahead of reads since input loses data
    case (bm)
      ddpd_pkg::BM_IDLE: begin
        if (di_run && di_full) begin
          next_bm = ddpd_pkg::BM_WRITE;
          next_mem_req = 1'b1;
          next_mem_we = 1'b1;
          next_mem_addr = di_base + {5'h00, di_idx, 2'b00};
        end else if (do_run && !do_full && do_idx != do_count) begin
          next_bm = ddpd_pkg::BM_READ;
          next_mem_req = 1'b1;
          next_mem_we = 1'b0;
          next_mem_addr = do_base + {5'h00, do_idx, 2'b00};
        end
      end
      ddpd_pkg::BM_WRITE: begin
        if (mem_ack) begin
          next_bm = ddpd_pkg::BM_IDLE;
          next_mem_req = 1'b0;
          next_mem_we = 1'b0;
          next_di_full = 1'b0;
          next_di_done = di_done + 25'h1;
          next_di_idx = di_idx + 25'h1;
          if (cfg[ddpd_pkg::CFG_DBL_BUF]) begin
            if (next_di_idx == di_half || next_di_idx == di_words) begin
              if (half_ready) begin
                next_overrun = overrun + 32'h1;
                next_irq_stat[ddpd_pkg::IRQ_OVERRUN] = 1'b1;
              end
              next_half_ready = 1'b1;
              next_ready_half = next_di_idx == di_words;
              next_irq_stat[ddpd_pkg::IRQ_HALF] = 1'b1;
              if (next_di_idx == di_words) begin
                next_di_idx = 25'h0;
              end
            end
          end else if (next_di_done == di_words) begin
            next_di_run = 1'b0;
            next_irq_stat[ddpd_pkg::IRQ_DI_DONE] = 1'b1;
          end
        end
      end
      ddpd_pkg::BM_READ: begin
        if (mem_ack) begin
          next_bm = ddpd_pkg::BM_IDLE;
          next_mem_req = 1'b0;
          next_do_hold = mem_rdata;
          next_do_full = 1'b1;
          next_do_idx = do_idx + 25'h1;
          if (cfg[ddpd_pkg::CFG_DO_REPEAT] && next_do_idx == do_count) begin
            next_do_idx = 25'h0;
          end
        end
      end
      default: next_bm = ddpd_pkg::BM_IDLE;
    endcase
    // start and stop; a stop leaves the bus cycle in flight to finish
    if (cmd_wr) begin
      if (reg_wdata[ddpd_pkg::CMD_DI_STOP]) begin
        next_di_run = 1'b0;
      end
      if (reg_wdata[ddpd_pkg::CMD_DO_STOP]) begin
        next_do_run = 1'b0;
      end
      if (reg_wdata[ddpd_pkg::CMD_DI_START] && di_ok) begin
        next_di_run = 1'b1;
        next_di_idx = 25'h0;
        next_di_done = 25'h0;
        next_di_full = 1'b0;
        next_half_ready = 1'b0;
        next_half_err = 1'b0;
        next_overrun = 32'h0;
      end
      if (reg_wdata[ddpd_pkg::CMD_DO_START] && do_ok) begin
        next_do_run = 1'b1;
        next_do_idx = 25'h0;
        next_do_done = 25'h0;
        next_do_full = 1'b0;
      end
    end
    // read port, unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        ddpd_pkg::OFS_CFG: next_reg_rdata = {24'h0, cfg};
        ddpd_pkg::OFS_STATUS: begin
          next_reg_rdata[ddpd_pkg::ST_DI_RUN] = di_run;
          next_reg_rdata[ddpd_pkg::ST_DO_RUN] = do_run;
          next_reg_rdata[ddpd_pkg::ST_HALF_READY] = half_ready;
          next_reg_rdata[ddpd_pkg::ST_READY_HALF] = ready_half;
          next_reg_rdata[ddpd_pkg::ST_HALF_ERR] = half_err;
        end
        ddpd_pkg::OFS_DIV_IN: next_reg_rdata = {16'h0, div[0]};
        ddpd_pkg::OFS_DIV_OUT: next_reg_rdata = {16'h0, div[1]};
        ddpd_pkg::OFS_DIV_PRE: next_reg_rdata = {16'h0, div[2]};
        ddpd_pkg::OFS_DI_BASE: next_reg_rdata = di_base;
        ddpd_pkg::OFS_DI_BYTES: next_reg_rdata = {5'h00, di_bytes};
        ddpd_pkg::OFS_DO_BASE: next_reg_rdata = do_base;
        ddpd_pkg::OFS_DO_SAMPLES: next_reg_rdata = {7'h00, do_count};
        ddpd_pkg::OFS_DI_DONE: next_reg_rdata = {7'h00, di_done};
        ddpd_pkg::OFS_DO_DONE: next_reg_rdata = {7'h00, do_done};
        ddpd_pkg::OFS_OVERRUN: next_reg_rdata = overrun;
        ddpd_pkg::OFS_IRQ_STAT: next_reg_rdata = {28'h0, irq_stat};
        ddpd_pkg::OFS_IRQ_MASK: next_reg_rdata = {28'h0, irq_mask};
        default: next_reg_rdata = 32'h0;
      endcase
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // register every next value
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= ddpd_pkg::CFG_RESET;
      for (int i = 0; i < 3; i++) begin
        div[i] <= ddpd_pkg::DIV_RESET;
      end
      di_base <= 32'h0;
      do_base <= 32'h0;
      di_bytes <= 27'h0;
      do_count <= 25'h0;
      irq_mask <= ddpd_pkg::MASK_RESET;
      irq_stat <= 4'h0;
      di_run <= 1'b0;
      do_run <= 1'b0;
      di_full <= 1'b0;
      do_full <= 1'b0;
      do_hold <= 32'h0;
      di_idx <= 25'h0;
      di_done <= 25'h0;
      do_idx <= 25'h0;
      do_done <= 25'h0;
      half_ready <= 1'b0;
      ready_half <= 1'b0;
      half_err <= 1'b0;
      overrun <= 32'h0;
      bm <= ddpd_pkg::BM_IDLE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 32'h0;
      out_data <= 32'h0;
      out_strobe <= 1'b0;
      in_ack <= 1'b0;
      out_ack <= 1'b0;
      reg_rdata <= 32'h0;
      irq <= 1'b0;
    end else begin
      cfg <= next_cfg;
      div <= next_div;
      di_base <= next_di_base;
      do_base <= next_do_base;
      di_bytes <= next_di_bytes;
      do_count <= next_do_count;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      di_run <= next_di_run;
      do_run <= next_do_run;
      di_full <= next_di_full;
      do_full <= next_do_full;
      do_hold <= next_do_hold;
      di_idx <= next_di_idx;
      di_done <= next_di_done;
      do_idx <= next_do_idx;
      do_done <= next_do_done;
      half_ready <= next_half_ready;
      ready_half <= next_ready_half;
      half_err <= next_half_err;
      overrun <= next_overrun;
      bm <= next_bm;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      out_data <= next_out_data;
      out_strobe <= next_out_strobe;
      in_ack <= next_in_ack;
      out_ack <= next_out_ack;
      reg_rdata <= next_reg_rdata;
      irq <= next_irq;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  property p_in_single;
    div_tick[0] && $past(!cfg[ddpd_pkg::CFG_DI_CASC]) |-> $past(rise[0]);
  endproperty
  a_in_single: assert property (p_in_single) else $error("in pace");
  property p_in_chain;
    div_tick[0] && $past(cfg[ddpd_pkg::CFG_DI_CASC]) |-> $past(div_tick[2]);
  endproperty
  a_in_chain: assert property (p_in_chain) else $error("in chain");
  property p_out_chain;
    div_tick[1] && $past(cfg[ddpd_pkg::CFG_DO_CASC]) |-> $past(div_tick[2]);
  endproperty
  a_out_chain: assert property (p_out_chain) else $error("out chain");
  property p_repeat_wrap;
    bm == ddpd_pkg::BM_READ && mem_ack && cfg[ddpd_pkg::CFG_DO_REPEAT] &&
      do_idx + 25'h1 == do_count && !cmd_wr |=> do_idx == 25'h0;
  endproperty
  a_repeat_wrap: assert property (p_repeat_wrap) else $error("wrap");
  property p_freeze;
    !do_run && !reg_wr |=> $stable(do_done) && !out_strobe;
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved");
  property p_half_cross;
    bm == ddpd_pkg::BM_WRITE && mem_ack && cfg[ddpd_pkg::CFG_DBL_BUF] &&
      di_idx + 25'h1 == di_half && !cmd_wr |=> half_ready && !ready_half;
  endproperty
  a_half_cross: assert property (p_half_cross) else $error("half");
  property p_overrun;
    bm == ddpd_pkg::BM_WRITE && mem_ack && cfg[ddpd_pkg::CFG_DBL_BUF] &&
      half_ready && !reg_wr && di_idx + 25'h1 == di_words
      |=> overrun == $past(overrun) + 32'h1 ##1 $stable(overrun);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun");
  property p_too_big;
    cmd_wr && reg_wdata[ddpd_pkg::CMD_DI_START] && !di_run &&
      di_bytes > ddpd_pkg::MAX_BYTES |=> !di_run;
  endproperty
  a_too_big: assert property (p_too_big) else $error("too big");
  property p_exact;
    do_run && !cfg[ddpd_pkg::CFG_DO_REPEAT] |-> do_done < do_count;
  endproperty
  a_exact: assert property (p_exact) else $error("over count");
  property p_stop_quiet;
    bm == ddpd_pkg::BM_IDLE && !di_run && !do_run |=> !mem_req;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("req");

  c_half: cover property (half_ready && ready_half);
  c_overrun: cover property (overrun == 32'h2);
  c_repeat: cover property (do_run && do_idx == 25'h0 && do_done > do_count);
  c_hshake: cover property (in_ack ##[1:20] !in_ack);

endmodule

/* ddpd_mem_model.sv */
// ddpd_mem_model: system memory answering bus-master words.
// assumes one request at a time, held until its ack.
`timescale 1ns/10ps
module ddpd_mem_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [2:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] store [0:255];
  logic [31:0] rd_q;
  logic [2:0] cnt;
  // preset words so that each read carries its own index
  initial for (int i = 0; i < 256; i++) store[i] = {8'hA5, 16'h0, i[7:0]};
  // stale data shows inverted so nothing can lean on it
  assign mem_rdata = mem_ack ? rd_q : ~rd_q;
  // answer after lat wait cycles, one word per request
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      cnt <= 3'h0;
      rd_q <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) begin
        cnt <= cnt + 3'h1;
        if (cnt >= lat) begin
          mem_ack <= 1'b1;
          cnt <= 3'h0;
          if (mem_we) store[mem_addr[9:2]] <= mem_wdata;
          else rd_q <= store[mem_addr[9:2]];
        end
      end
    end
  end
endmodule

/* tb_dio_dma_pacer_dblbuf.sv */
// tb: drives registers, pins and a random memory delay.
// assumes the memory model and a free-running reference pin.
`timescale 1ns/10ps
module tb_dio_dma_pacer_dblbuf;
  logic core_clk = 1'b0, reset_n = 1'b0, ref_clk_pin = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, in_req = 1'b0, out_req = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, in_data = 32'h0, inw [0:3];
  logic [31:0] reg_rdata, out_data, mem_addr, mem_wdata, mem_rdata, v;
  logic irq, in_ack, out_strobe, out_ack, mem_req, mem_we, mem_ack;
  logic [2:0] lat = 3'h0;
  logic [31:0] outq [$];
  integer seed = 32'h1c1c776a, fail_count = 0, n_checks = 0;
  ddpd_top dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .ref_clk_pin, .in_data, .in_req, .in_ack,
    .out_data, .out_strobe, .out_req, .out_ack, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  ddpd_mem_model mem (.core_clk, .reset_n, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .lat, .mem_ack, .mem_rdata);
  initial forever #50 core_clk = ~core_clk;
  // the agree filter needs two samples per level, so the reference runs
  // at 2 MHz here and off the clock edge; rates count reference ticks
  initial #20 forever #250 ref_clk_pin = ~ref_clk_pin;
  // random memory delay; record each output sample
  always @(posedge core_clk) begin
    lat <= $random(seed);
    if (out_strobe === 1'b1) outq.push_back(out_data);
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // bounded polls of a status bit or of in_ack
  task wst(input int b, input logic e, input bit pin);
    int k;
    for (k = 0; k < 600; k++) begin
      if (pin) @(posedge core_clk);
      if (pin) #1 v[b] = in_ack;
      else rd(ddpd_pkg::OFS_STATUS);
      if (v[b] === e) break;
    end
    if (k == 600) begin
      fail_count++;
      summarize();
    end
  endtask
  // n handshaken input words with random data
  task hs(input int n);
    for (int i = 0; i < n; i++) begin
      inw[i] = $random(seed);
      in_data <= inw[i];
      in_req <= 1'b1;
      wst(0, 1'b1, 1'b1);
      in_req <= 1'b0;
      wst(0, 1'b0, 1'b1);
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(ddpd_pkg::OFS_DIV_PRE);
    chk(v, 32'h2);
    rd(8'hFC);
    chk(v, 32'h0);
    // gated output pacer, handshake input
    wr(ddpd_pkg::OFS_CFG, 32'h70);
    wr(ddpd_pkg::OFS_IRQ_MASK, 32'h3);
    out_req <= 1'b1;
    wr(ddpd_pkg::OFS_DO_BASE, 32'h40);
    wr(ddpd_pkg::OFS_DO_SAMPLES, 32'h3);
    wr(ddpd_pkg::OFS_CMD, 32'h4);
    wst(ddpd_pkg::ST_DO_RUN, 1'b0, 1'b0);
    rd(ddpd_pkg::OFS_DO_DONE);
    chk(v, 32'h3);
    chk(32'(outq.size()), 32'h3);
    for (int i = 0; i < 3; i++) chk(outq[i], 32'hA5000010 + i);
    chk({31'h0, irq}, 32'h1);
    // two handshaken input words, random data
    wr(ddpd_pkg::OFS_DI_BASE, 32'h80);
    wr(ddpd_pkg::OFS_DI_BYTES, 32'h8);
    wr(ddpd_pkg::OFS_CMD, 32'h1);
    hs(2);
    wst(ddpd_pkg::ST_DI_RUN, 1'b0, 1'b0);
    rd(ddpd_pkg::OFS_DI_DONE);
    chk(v, 32'h2);
    chk(mem.store[32], inw[0]);
    chk(mem.store[33], inw[1]);
    wr(ddpd_pkg::OFS_CMD, 32'h10);
    rd(ddpd_pkg::OFS_STATUS);
    chk({31'h0, v[4]}, 32'h1);
    wr(ddpd_pkg::OFS_IRQ_STAT, 32'hF);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    // oversized input start is refused
    wr(ddpd_pkg::OFS_DI_BYTES, 32'h4000004);
    wr(ddpd_pkg::OFS_CMD, 32'h1);
    rd(ddpd_pkg::OFS_STATUS);
    chk({31'h0, v[0]}, 32'h0);
    // ring of two one-word halves, four words: three overruns
    wr(ddpd_pkg::OFS_CFG, 32'h38);
    wr(ddpd_pkg::OFS_DI_BYTES, 32'h8);
    wr(ddpd_pkg::OFS_CMD, 32'h1);
    hs(4);
    // let the last bus write land before looking
    repeat (20) @(posedge core_clk);
    rd(ddpd_pkg::OFS_OVERRUN);
    chk(v, 32'h3);
    chk(mem.store[32], inw[2]);
    chk(mem.store[33], inw[3]);
    rd(ddpd_pkg::OFS_STATUS);
    chk(v, 32'hD);
    wr(ddpd_pkg::OFS_CMD, 32'h12);
    rd(ddpd_pkg::OFS_STATUS);
    chk(v, 32'h8);
    // chained output pacer with repeat: the fourth sample wraps
    wr(ddpd_pkg::OFS_DIV_PRE, 32'h2);
    wr(ddpd_pkg::OFS_CFG, 32'h06);
    outq.delete();
    wr(ddpd_pkg::OFS_CMD, 32'h4);
    for (int k = 0; k < 3000 && outq.size() < 5; k++) @(posedge core_clk);
    chk({31'h0, outq.size() > 4}, 32'h1);
    wr(ddpd_pkg::OFS_CMD, 32'h8);
    rd(ddpd_pkg::OFS_DO_DONE);
    chk(v, 32'(outq.size()));
    chk(outq[3], 32'hA5000010);
    summarize();
  end
endmodule
